// ===== shared/ptr_pkg.sv
// Shared constants for the routed general-purpose port controller.
// Assumes a 32-bit Avalon-MM register bus with byte addresses and one word per register.
package ptr_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned PTR_ADDR_W = 8;
  localparam int unsigned PTR_DATA_W = 32;
  localparam int unsigned PTR_PORT_W = 8;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PTR_OFS_DATA = 8'h00;
  localparam logic [7:0] PTR_OFS_INPUT = 8'h04;
  localparam logic [7:0] PTR_OFS_DIR = 8'h08;
  localparam logic [7:0] PTR_OFS_DRIVE = 8'h0c;
  localparam logic [7:0] PTR_OFS_PULL_EN = 8'h10;
  localparam logic [7:0] PTR_OFS_PULL_POL = 8'h14;
  localparam logic [7:0] PTR_OFS_RSVD = 8'h18;
  localparam logic [7:0] PTR_OFS_ROUTE = 8'h1c;

  // ----------------------------------------------------------------
  // Reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] PTR_RST_CFG = 8'h00;
  localparam logic [7:0] PTR_RSVD_VALUE = 8'h00;
  // Routing bit 3 has no function and is kept at zero
  localparam logic [7:0] PTR_ROUTE_MASK = 8'hf7;
  localparam logic [31:0] PTR_RDATA_ZERO = 32'h0000_0000;
  localparam int unsigned PTR_PWM_LO = 4;
  localparam int unsigned PTR_TIM_ROUTE_HI = 2;
  localparam int unsigned PTR_API_BIT = 5;

endpackage : ptr_pkg

// ===== rtl/ptr_port_ctrl.sv
// Pin control and routing for one 8-bit port shared with timer, routed PWM and wakeup output.
// Assumes synchronous pin inputs, one 100 MHz clock and an Avalon-MM master with waitrequest.
//
// Operation
// [RULE1] Input register returns live buffered pin states
// [RULE2] Input register writes ignored, reads always allowed
// [RULE3] Direction one drives pin, zero releases it
// [RULE4] Enabled timer compare forces output, direction untouched
// [RULE5] Routed PWM forces bits 7..4 next
// [RULE6] Wakeup output forces bit 5 last
// [RULE7] Reduced drive selects fifth strength, outputs only
// [RULE8] Reduced drive applies whatever function drives pin
// [RULE9] Pull enable acts only while pin inputs
// [RULE10] Polarity one pulls down, zero pulls up
// [RULE11] Reserved register reads zero, ignores writes
// [RULE12] Routing 7..4 one puts PWM here
// [RULE13] Routing 2..0 one moves timer away
// [RULE14] Configuration registers accessible at any time
// [RULE15] Data read: register if output, else pin
// [RULE16] Output priority timer, PWM, wakeup, data
// [RULE17] Configuration resets zero; routing bit three zero
//
// Local design decisions: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps

module ptr_port_ctrl
  import ptr_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [ptr_pkg::PTR_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [ptr_pkg::PTR_DATA_W-1:0] avs_writedata_i,
  output logic [ptr_pkg::PTR_DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Pins of this port
  input wire logic [ptr_pkg::PTR_PORT_W-1:0] pin_in_i,
  output logic [ptr_pkg::PTR_PORT_W-1:0] pin_out_o,
  output logic [ptr_pkg::PTR_PORT_W-1:0] pin_oe_o,
  output logic [ptr_pkg::PTR_PORT_W-1:0] pin_reduced_drive_o,
  output logic [ptr_pkg::PTR_PORT_W-1:0] pin_pull_en_o,
  output logic [ptr_pkg::PTR_PORT_W-1:0] pin_pull_down_o,
  // Timer, PWM and wakeup peripherals
  input wire logic [7:0] tim_oc_en_i,
  input wire logic [7:0] tim_out_i,
  input wire logic [7:4] pwm_en_i,
  input wire logic [7:4] pwm_out_i,
  input wire logic api_en_i,
  input wire logic api_out_i,
  // Channels handed to the second port
  output logic [7:4] sp_pwm_en_o,
  output logic [7:4] sp_pwm_out_o,
  output logic [2:0] sp_tim_en_o,
  output logic [2:0] sp_tim_out_o
);

  import ptr_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] data_r, data_nxt;
  logic [7:0] dir_r, dir_nxt;
  logic [7:0] drive_r, drive_nxt;
  logic [7:0] pull_en_r, pull_en_nxt;
  logic [7:0] pull_pol_r, pull_pol_nxt;
  logic [7:0] route_r, route_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wait_r, wait_nxt;
  logic req;
  logic done;
  logic [7:0] rd_byte;
  logic [7:0] data_view;

  // ----------------------------------------------------------------
  // Bus slave and register file
  // ----------------------------------------------------------------
  // Every access takes exactly one wait cycle; the answer is registered so
  // readdata and waitrequest both come straight from flip-flops.
  assign req = avs_read_i | avs_write_i;
  assign done = req & ~wait_r;
  assign data_view = (dir_r & data_r) | (~dir_r & pin_in_i);  // [RULE15]

  always_comb
  begin
    data_nxt = data_r;
    dir_nxt = dir_r;
    drive_nxt = drive_r;
    pull_en_nxt = pull_en_r;
    pull_pol_nxt = pull_pol_r;
    route_nxt = route_r;
    rdata_nxt = rdata_r;
    wait_nxt = ~(req & wait_r);
    rd_byte = 8'h00;
    unique case (avs_address_i)
      PTR_OFS_DATA: rd_byte = data_view;
      PTR_OFS_INPUT: rd_byte = pin_in_i;  // [RULE1]
      PTR_OFS_DIR: rd_byte = dir_r;
      PTR_OFS_DRIVE: rd_byte = drive_r;
      PTR_OFS_PULL_EN: rd_byte = pull_en_r;
      PTR_OFS_PULL_POL: rd_byte = pull_pol_r;
      PTR_OFS_RSVD: rd_byte = PTR_RSVD_VALUE;  // [RULE11]
      PTR_OFS_ROUTE: rd_byte = route_r & PTR_ROUTE_MASK;
      default: rd_byte = 8'h00;
    endcase
    if (avs_read_i && wait_r)
    begin
      rdata_nxt = {24'h00_0000, rd_byte};
    end
    // Writes land on the completing edge; input and reserved slots drop them
    if (avs_write_i && !wait_r)
    begin
      unique case (avs_address_i)
        PTR_OFS_DATA: data_nxt = avs_writedata_i[7:0];
        PTR_OFS_DIR: dir_nxt = avs_writedata_i[7:0];
        PTR_OFS_DRIVE: drive_nxt = avs_writedata_i[7:0];  // [RULE14]
        PTR_OFS_PULL_EN: pull_en_nxt = avs_writedata_i[7:0];  // [RULE14]
        PTR_OFS_PULL_POL: pull_pol_nxt = avs_writedata_i[7:0];  // [RULE14]
        PTR_OFS_ROUTE: route_nxt = avs_writedata_i[7:0] & PTR_ROUTE_MASK;  // [RULE17]
        default: data_nxt = data_r;  // [RULE2] [RULE11]
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      data_r <= PTR_RST_CFG;  // [RULE17]
      dir_r <= PTR_RST_CFG;
      drive_r <= PTR_RST_CFG;
      pull_en_r <= PTR_RST_CFG;
      pull_pol_r <= PTR_RST_CFG;
      route_r <= PTR_RST_CFG;
      rdata_r <= PTR_RDATA_ZERO;
      wait_r <= 1'b1;
    end
    else
    begin
      data_r <= data_nxt;
      dir_r <= dir_nxt;
      drive_r <= drive_nxt;
      pull_en_r <= pull_en_nxt;
      pull_pol_r <= pull_pol_nxt;
      route_r <= route_nxt;
      rdata_r <= rdata_nxt;
      wait_r <= wait_nxt;
    end
  end

  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = wait_r;

  // ----------------------------------------------------------------
  // Per-pin function selection
  // ----------------------------------------------------------------
  logic [7:0] tim_here, pwm_here, api_here, pwm_val;
  logic [7:0] force_w, oe_w, val_w;

  for (genvar gi = 0; gi < 8; gi++)
  begin : g_pin
    if (gi <= PTR_TIM_ROUTE_HI)
    begin : g_tim_rt
      assign tim_here[gi] = tim_oc_en_i[gi] & ~route_r[gi];  // [RULE13]
    end
    else
    begin : g_tim_fix
      assign tim_here[gi] = tim_oc_en_i[gi];
    end
    if (gi >= PTR_PWM_LO)
    begin : g_pwm
      assign pwm_here[gi] = pwm_en_i[gi] & route_r[gi];  // [RULE12]
      assign pwm_val[gi] = pwm_out_i[gi];
    end
    else
    begin : g_nopwm
      // Lower pins have no PWM channel, so nothing out of range is ever selected
      assign pwm_here[gi] = 1'b0;
      assign pwm_val[gi] = 1'b0;
    end
    if (gi == PTR_API_BIT)
    begin : g_api
      assign api_here[gi] = api_en_i;
    end
    else
    begin : g_noapi
      assign api_here[gi] = 1'b0;
    end
    // Forcing never touches dir_r, so software sees its own direction back
    assign force_w[gi] = tim_here[gi] | pwm_here[gi] | api_here[gi];  // [RULE4] [RULE5] [RULE6]
    assign oe_w[gi] = dir_r[gi] | force_w[gi];  // [RULE3]
    assign val_w[gi] = tim_here[gi] ? tim_out_i[gi] :
                       pwm_here[gi] ? pwm_val[gi] :
                       api_here[gi] ? api_out_i : data_r[gi];  // [RULE16]
  end

  // ----------------------------------------------------------------
  // Registered pin and hand-over outputs
  // ----------------------------------------------------------------
  // One cycle of latency is paid so that every pad control is glitch free.
  logic [7:0] out_r, out_nxt, oe_r, oe_nxt, rdrv_r, rdrv_nxt;
  logic [7:0] pe_r, pe_nxt, pd_r, pd_nxt;
  logic [7:4] spe_r, spe_nxt, spo_r, spo_nxt;
  logic [2:0] ste_r, ste_nxt, sto_r, sto_nxt;

  always_comb
  begin
    out_nxt = val_w;
    oe_nxt = oe_w;
    rdrv_nxt = drive_r & oe_w;  // [RULE7] [RULE8]
    pe_nxt = pull_en_r & ~oe_w;  // [RULE9]
    pd_nxt = pull_pol_r & pull_en_r & ~oe_w;  // [RULE10]
    spe_nxt = pwm_en_i & ~route_r[7:4];  // [RULE12]
    spo_nxt = pwm_out_i;
    ste_nxt = tim_oc_en_i[2:0] & route_r[2:0];  // [RULE13]
    sto_nxt = tim_out_i[2:0];
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      out_r <= PTR_RST_CFG;
      oe_r <= PTR_RST_CFG;
      rdrv_r <= PTR_RST_CFG;
      pe_r <= PTR_RST_CFG;
      pd_r <= PTR_RST_CFG;
      spe_r <= 4'h0;
      spo_r <= 4'h0;
      ste_r <= 3'h0;
      sto_r <= 3'h0;
    end
    else
    begin
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      rdrv_r <= rdrv_nxt;
      pe_r <= pe_nxt;
      pd_r <= pd_nxt;
      spe_r <= spe_nxt;
      spo_r <= spo_nxt;
      ste_r <= ste_nxt;
      sto_r <= sto_nxt;
    end
  end

  assign pin_out_o = out_r;
  assign pin_oe_o = oe_r;
  assign pin_reduced_drive_o = rdrv_r;
  assign pin_pull_en_o = pe_r;
  assign pin_pull_down_o = pd_r;
  assign sp_pwm_en_o = spe_r;
  assign sp_pwm_out_o = spo_r;
  assign sp_tim_en_o = ste_r;
  assign sp_tim_out_o = sto_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_input_read_live: assert property (@(posedge sys_clk_i) disable iff (rst_i)  // [RULE1]
    (avs_read_i && wait_r && avs_address_i == PTR_OFS_INPUT)
    |=> (!avs_waitrequest_o && avs_readdata_o[7:0] == $past(pin_in_i)))
    else $error("input register read did not return pin state");

  a_input_write_ignored: assert property (@(posedge sys_clk_i) disable iff (rst_i)  // [RULE2]
    (done && avs_write_i && avs_address_i == PTR_OFS_INPUT)
    |=> ($stable(data_r) && $stable(dir_r) && $stable(drive_r) && $stable(pull_en_r)
         && $stable(pull_pol_r) && $stable(route_r)))
    else $error("write to input register changed state");

  a_dir_drives_out: assert property (@(posedge sys_clk_i) disable iff (rst_i)  // [RULE3]
    (dir_r[0] || tim_oc_en_i[0] && !route_r[0]) |=> pin_oe_o[0])
    else $error("output enable missing on pin 0");

  a_timer_forces_pin: assert property (@(posedge sys_clk_i) disable iff (rst_i)  // [RULE4] [RULE16]
    (tim_oc_en_i[7] && !dir_r[7])
    |=> (pin_oe_o[7] && pin_out_o[7] == $past(tim_out_i[7]) && !dir_r[7]))
    else $error("timer did not take pin 7");

  a_pwm_forces_pin: assert property (@(posedge sys_clk_i) disable iff (rst_i)  // [RULE5] [RULE12]
    (pwm_en_i[6] && route_r[6] && !tim_oc_en_i[6])
    |=> (pin_oe_o[6] && pin_out_o[6] == $past(pwm_out_i[6]) && !sp_pwm_en_o[6]))
    else $error("routed pwm did not take pin 6");

  a_api_forces_pin: assert property (@(posedge sys_clk_i) disable iff (rst_i)  // [RULE6]
    (api_en_i && !tim_oc_en_i[5] && !(pwm_en_i[5] && route_r[5]))
    |=> (pin_oe_o[5] && pin_out_o[5] == $past(api_out_i)))
    else $error("wakeup output did not take pin 5");

  a_drive_only_out: assert property (@(posedge sys_clk_i) disable iff (rst_i)  // [RULE7] [RULE8]
    ((pin_reduced_drive_o & ~pin_oe_o) == 8'h00)
    and (drive_r[4] && pwm_en_i[4] && route_r[4] |=> pin_reduced_drive_o[4]))
    else $error("reduced drive wrong");

  a_pull_only_in: assert property (@(posedge sys_clk_i) disable iff (rst_i)  // [RULE9] [RULE10]
    ((pin_pull_en_o & pin_oe_o) == 8'h00)
    and (pull_en_r[1] && !oe_w[1] |=> pin_pull_en_o[1] && pin_pull_down_o[1] == $past(pull_pol_r[1])))
    else $error("pull device control wrong");

  a_rsvd_reads_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)  // [RULE11]
    (avs_read_i && wait_r && avs_address_i == PTR_OFS_RSVD) |=> avs_readdata_o == PTR_RDATA_ZERO)
    else $error("reserved register read non-zero");

  a_timer_rerouted: assert property (@(posedge sys_clk_i) disable iff (rst_i)  // [RULE13]
    (tim_oc_en_i[2] && route_r[2] && !dir_r[2]) |=> (sp_tim_en_o[2] && !pin_oe_o[2]))
    else $error("timer channel 2 not moved to second port");

  a_cfg_write_lands: assert property (@(posedge sys_clk_i) disable iff (rst_i)  // [RULE14]
    (done && avs_write_i && avs_address_i == PTR_OFS_PULL_POL)
    |=> pull_pol_r == $past(avs_writedata_i[7:0]))
    else $error("polarity write lost");

  a_data_read_view: assert property (@(posedge sys_clk_i) disable iff (rst_i)  // [RULE15]
    (avs_read_i && wait_r && avs_address_i == PTR_OFS_DATA)
    |=> avs_readdata_o[7:0] == (($past(dir_r) & $past(data_r)) | (~$past(dir_r) & $past(pin_in_i))))
    else $error("data register read source wrong");

  a_route_bit3_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)  // [RULE17]
    route_r[3] == 1'b0)
    else $error("routing bit 3 set");

  a_wait_one_cycle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (req && wait_r) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer timing wrong");

endmodule : ptr_port_ctrl

// ===== tb/ptr_pin_model.sv
// Far-side model of the eight port pins: the level that the port samples back on its input.
// Assumes the port's registered pin controls; the bench supplies shorts and a floating pattern.
`timescale 1ns/1ps

module ptr_pin_model
  import ptr_pkg::*;
(
  // Port side
  input wire logic [ptr_pkg::PTR_PORT_W-1:0] pin_out_i,
  input wire logic [ptr_pkg::PTR_PORT_W-1:0] pin_oe_i,
  input wire logic [ptr_pkg::PTR_PORT_W-1:0] pull_en_i,
  input wire logic [ptr_pkg::PTR_PORT_W-1:0] pull_down_i,
  // Bench side
  input wire logic [ptr_pkg::PTR_PORT_W-1:0] short_mask_i,
  input wire logic [ptr_pkg::PTR_PORT_W-1:0] short_val_i,
  input wire logic [ptr_pkg::PTR_PORT_W-1:0] float_i,
  output logic [ptr_pkg::PTR_PORT_W-1:0] pin_o
);
  // A short beats any driver, so an overloaded output shows on the input
  always_comb
  begin
    for (int b = 0; b < PTR_PORT_W; b++)
    begin
      if (short_mask_i[b])
        pin_o[b] = short_val_i[b];
      else if (pin_oe_i[b])
        pin_o[b] = pin_out_i[b];
      else if (pull_en_i[b])
        pin_o[b] = ~pull_down_i[b];
      else
        pin_o[b] = float_i[b];
    end
  end
endmodule : ptr_pin_model

// ===== tb/ptr_port_ctrl_tb.sv
// Self-checking bench for the routed port controller.
// Assumes the pin model on the far side and an Avalon-MM master built from tasks.
`timescale 1ns/1ps

module ptr_port_ctrl_tb;
  import ptr_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r;} ptr_row_t;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, api_en = 1'b0, api_out = 1'b0, wq;
  logic [7:0] addr = 8'h00, pin, pout, poe, prd, ppe, ppd, tim_en = 8'h00, tim_out = 8'h00;
  logic [7:0] smask = 8'h00, sval = 8'h00, flt = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] pwm_en = 4'h0, pwm_out = 4'h0, spe, spo;
  logic [2:0] ste, sto;
  int err_total = 0, n_compared = 0;
  ptr_row_t rows [7] = '{'{8'h08, 32'ha5, 32'ha5}, '{8'h0c, 32'h3c, 32'h3c}, '{8'h10, 32'hff, 32'hff},
    '{8'h14, 32'h0f, 32'h0f}, '{8'h1c, 32'hff, 32'hf7}, '{8'h18, 32'hff, 32'h00}, '{8'h20, 32'hff, 32'h00}};

  initial
  begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) flt <= ~flt;

  ptr_port_ctrl ptr_port_ctrl_i (.sys_clk_i(clk), .rst_i(rst), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(wq),
    .pin_in_i(pin), .pin_out_o(pout), .pin_oe_o(poe), .pin_reduced_drive_o(prd), .pin_pull_en_o(ppe),
    .pin_pull_down_o(ppd), .tim_oc_en_i(tim_en), .tim_out_i(tim_out), .pwm_en_i(pwm_en),
    .pwm_out_i(pwm_out), .api_en_i(api_en), .api_out_i(api_out), .sp_pwm_en_o(spe),
    .sp_pwm_out_o(spo), .sp_tim_en_o(ste), .sp_tim_out_o(sto));

  ptr_pin_model ptr_pin_model_i (.pin_out_i(pout), .pin_oe_i(poe), .pull_en_i(ppe), .pull_down_i(ppd),
    .short_mask_i(smask), .short_val_i(sval), .float_i(flt), .pin_o(pin));

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  // Each access starts one edge late so a strobe is never lowered and raised at one edge
  task bus(input logic we, input logic [7:0] a, input logic [31:0] w, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= w;
    rd <= ~we;
    wr <= we;
    @(posedge clk);
    while (wq !== 1'b0 && n < 20)
    begin
      n++;
      @(posedge clk);
    end
    if (n >= 20)
      err_total++;
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // Outputs lag their causes by one edge; two edges and a small step leave them settled
  task settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task conclude;
    $display("Compared %0d values, %0d mismatches", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(wq, 1'b1, "idle wait");
    chk({prd, ppe, ppd, poe}, 32'h0, "pins at reset");
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b0, 8'h08 + 8'(4 * i), 32'h0, d);
      chk(d, 32'h0, "config reset");
    end
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].a, rows[i].w, d);
      bus(1'b0, rows[i].a, 32'h0, d);
      chk(d, rows[i].r, "register");
    end
    settle();
    chk(poe, 8'ha5, "direction");
    chk(prd, 8'h24, "reduced drive");
    chk(ppe, 8'h5a, "pull enable");
    chk(ppd, 8'h0a, "pull down");
    @(posedge clk);
    smask <= 8'h01;
    sval <= 8'h01;
    bus(1'b0, PTR_OFS_INPUT, 32'h0, d);
    chk(d, 32'h51, "input sample");
    bus(1'b1, PTR_OFS_INPUT, 32'hff, d);
    bus(1'b0, PTR_OFS_DIR, 32'h0, d);
    chk(d, 32'ha5, "input write");
    bus(1'b0, PTR_OFS_DATA, 32'h0, d);
    chk(d, 32'h50, "data from pins");
    bus(1'b1, PTR_OFS_DATA, 32'hff, d);
    bus(1'b0, PTR_OFS_DATA, 32'h0, d);
    chk(d, 32'hf5, "data mixed");
    bus(1'b1, PTR_OFS_DATA, 32'h0, d);
    bus(1'b1, PTR_OFS_DIR, 32'h0, d);
    tim_en <= 8'h88;
    tim_out <= 8'h08;
    pwm_en <= 4'hf;
    pwm_out <= 4'ha;
    api_en <= 1'b1;
    settle();
    chk(poe, 8'hf8, "forced enable");
    chk(pout & poe, 8'h28, "priority");
    chk(prd, 8'h38, "drive on forced");
    chk(ppe, 8'h07, "pull on forced");
    bus(1'b0, PTR_OFS_DIR, 32'h0, d);
    chk(d, 32'h0, "direction kept");
    @(posedge clk);
    pwm_en <= 4'h0;
    settle();
    chk({poe, pout & poe}, 16'ha808, "wakeup force");
    @(posedge clk);
    pwm_en <= 4'h5;
    api_en <= 1'b0;
    settle();
    chk({poe, pout & poe}, 16'hd808, "pwm force");
    @(posedge clk);
    tim_en <= 8'h07;
    tim_out <= 8'h05;
    pwm_en <= 4'hf;
    settle();
    chk({poe, 1'b0, ste, 1'b0, sto, spe}, 32'h000f_0750, "timer routed away");
    bus(1'b1, PTR_OFS_ROUTE, 32'h0, d);
    settle();
    chk({poe, pout & poe, 1'b0, ste}, 32'h0000_7050, "timer kept");
    chk({spe, spo}, 8'hfa, "pwm to second port");
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, PTR_OFS_PULL_EN, 32'h0, d);
    chk(d, 32'h0, "second reset");
    conclude();
  end
endmodule : ptr_port_ctrl_tb
